// >>> hdl/pps_pkg.sv
package pps_pkg;
  // ==========================================================
  // Register indices (byte address is four times the index)
  localparam logic [7:0] IDX_B3_VOUT = 8'h00;
  localparam logic [7:0] IDX_B1_VOUT = 8'h01;
  localparam logic [7:0] IDX_B2_VOUT = 8'h02;
  localparam logic [7:0] IDX_SLEEP_LVL = 8'h09;
  localparam logic [7:0] IDX_BUCK_CTRL = 8'h0a;
  localparam logic [7:0] IDX_STATUS = 8'h10;
  // ==========================================================
  // Buck control fields
  localparam int CTRL_B1EN_BIT = 0;
  localparam int CTRL_B2EN_BIT = 1;
  localparam int CTRL_FFF_LSB = 2;
  localparam logic [4:0] CTRL_RST = 5'h03;
  // ==========================================================
  // Voltage codes (plain values, one step per code)
  localparam logic [7:0] VOUT_B1_3V0 = 8'h3c;
  localparam logic [7:0] VOUT_B2_3V0 = 8'h3c;
  localparam logic [7:0] VOUT_B2_1V8 = 8'h24;
  localparam logic [7:0] VOUT_B3_1V2 = 8'h18;
  localparam logic [7:0] VOUT_B3_1V0 = 8'h14;
  localparam logic [7:0] SLEEP_LVL_RST = 8'h10;
  // ==========================================================
  // Timing
  localparam int CLK_HZ = 50_000_000;
  localparam int T_DECIDE_MS = 15;
  localparam int T_STEP_MS = 2;
  localparam int T_ARM_S = 1;
  localparam int T_SS_STEP_US = 50;
  localparam int CYC_DECIDE = T_DECIDE_MS * (CLK_HZ / 1000);
  localparam int CYC_STEP = T_STEP_MS * (CLK_HZ / 1000);
  localparam int CYC_ARM = T_ARM_S * CLK_HZ;
  localparam int CYC_SS_STEP = T_SS_STEP_US * (CLK_HZ / 1_000_000);
  // ==========================================================
  // Sequencer and switch phase states
  typedef enum logic [3:0] {
    S_OFF, S_DECIDE, S_LDO, S_B1, S_B2, S_RUN,
    S_SLP_B3, S_SLP_B2, S_SLEEP, S_WAKE, S_FAULT
  } pps_seq_type;
  typedef enum logic [1:0] {PH_IDLE, PH_HS, PH_LS} pps_ph_type;
endpackage

// >>> hdl/pps_sequencer.sv
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - Light-load: high side on below upper threshold, low side until zero current, then idle.
// - Idle light-load restarts switching when output drops below lower threshold.
// - Output below second lower threshold in light-load forces fixed-frequency operation.
// - Switch current limit rises in steps during each buck's start-up.
// - Short circuit: hold low side until current below low threshold before next cycle.
// - Bypass monitored while enabled; dropped above 3.5 V (buck one) or 2.6 V (two).
// - Bypass uses extra parallel switch plus high side on buck one, high side only on two.
// - Dropout: high side held fully on, no switching.
// - Any buck below 85 percent shuts other outputs; restart once condition clears.
// - Wait 15 ms after lockout release before choosing buck configuration.
// - Input below 3.6 V at start: bucks one and two in bypass, else regulate.
// - Start order: linear regulator, 2 ms, buck one, 2 ms, buck two, 2 ms, buck three.
// - No enable input; power-up starts automatically, linear regulator stays on.
// - Host may disable bucks one and two through per-buck enable bits.
// - Reset pin low returns every register, voltage settings included, to default.
// - Sleep request disables bucks one, two and moves buck three to sleep level.
// - Sleep entry: buck three to sleep level, 2 ms, buck two off, 2 ms, buck one off.
// - Sleep request ignored until 1 s after power-up.
// - Bucks one and two already off at sleep: buck three keeps its level.
// - Disabled bucks one and two have their outputs pulled to ground.
// - Wake: buck one restored, 2 ms later bucks two and three restored together.
// - Voltage-select inputs sampled only at start-up.
// - Lockout forces reset of all state; recovery starts a new power-up.
module pps_sequencer
  import pps_pkg::*;
#(
  parameter int DECIDE_CYC = CYC_DECIDE,
  parameter int STEP_CYC = CYC_STEP,
  parameter int ARM_CYC = CYC_ARM,
  parameter int SS_CYC = CYC_SS_STEP,
  parameter int ILIM_W = 3
) (
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Supply and host pins
  input wire logic vin_above_uvlo,
  input wire logic reset_pin_n,
  input wire logic sleep_request,
  input wire logic buck2_voltage_select,
  input wire logic buck3_voltage_select,
  input wire logic vin_below_3v6,
  input wire logic vin_above_3v5,
  input wire logic vin_above_2v6,
  // Per-buck analog comparators, bit i is buck i+1
  input wire logic [2:0] fb_above_hi,
  input wire logic [2:0] fb_below_lo,
  input wire logic [2:0] fb_below_lo2,
  input wire logic [2:0] il_zero,
  input wire logic [2:0] il_below_low,
  input wire logic [2:0] light_load,
  input wire logic [2:0] pwm_on_req,
  input wire logic [2:0] short_det,
  input wire logic [2:0] dropout_req,
  input wire logic [2:0] out_of_reg,
  // Power stage controls
  output logic ldo_en,
  output logic [2:0] buck_en,
  output logic [2:0] hs_on,
  output logic [2:0] ls_on,
  output logic bypass_fet_on,
  output logic [1:0] discharge_on,
  output logic [2:0] pfm_mode,
  output logic [3*ILIM_W-1:0] ilim_step,
  output logic [7:0] b1_vout,
  output logic [7:0] b2_vout,
  output logic [7:0] b3_vout
);
  // ==========================================================
  // Soft reset from the reset pin and supply lockout
  logic srst;
  assign srst = !reset_pin_n || !vin_above_uvlo;

  function automatic logic [11:0] baddr(input logic [7:0] idx);
    baddr = {2'h0, idx, 2'h0};
  endfunction

  // ==========================================================
  // Registers
  logic [4:0] ctrl_ff;
  logic [7:0] sleep_lvl_ff, vb1_ff, vb2_ff, vb3_ff;
  logic [1:0] bypass_ff;
  logic [2:0] pfm_ff, short_ff;
  pps_seq_type st_ff, nxt_st;
  pps_ph_type ph_ff [3];
  logic [31:0] cnt_ff, arm_cnt_ff;
  logic armed_ff, b3_slp_ff, b2_down_ff;
  logic wr, done;
  assign wr = psel && penable && pwrite && pready;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= CTRL_RST;
      sleep_lvl_ff <= SLEEP_LVL_RST;
      vb1_ff <= VOUT_B1_3V0;
      vb2_ff <= VOUT_B2_3V0;
      vb3_ff <= VOUT_B3_1V2;
    end else if (srst) begin
      ctrl_ff <= CTRL_RST;
      sleep_lvl_ff <= SLEEP_LVL_RST;
      vb1_ff <= VOUT_B1_3V0;
      vb2_ff <= VOUT_B2_3V0;
      vb3_ff <= VOUT_B3_1V2;
    end else if (st_ff == S_DECIDE && done) begin
      // Selects are looked at once here and never again
      vb2_ff <= buck2_voltage_select ? VOUT_B2_3V0 : VOUT_B2_1V8;
      vb3_ff <= buck3_voltage_select ? VOUT_B3_1V2 : VOUT_B3_1V0;
    end else if (wr) begin
      case (paddr)
        baddr(IDX_BUCK_CTRL): ctrl_ff <= pwdata[4:0];
        baddr(IDX_SLEEP_LVL): sleep_lvl_ff <= pwdata[7:0];
        baddr(IDX_B1_VOUT): vb1_ff <= pwdata[7:0];
        baddr(IDX_B2_VOUT): vb2_ff <= pwdata[7:0];
        baddr(IDX_B3_VOUT): vb3_ff <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // ==========================================================
  // APB answer: zero wait states, error on unmapped address
  logic mapped;
  logic [31:0] rdata;
  always_comb begin
    mapped = 1'b1;
    rdata = 32'h0;
    case (paddr)
      baddr(IDX_BUCK_CTRL): rdata = {27'h0, ctrl_ff};
      baddr(IDX_SLEEP_LVL): rdata = {24'h0, sleep_lvl_ff};
      baddr(IDX_B1_VOUT): rdata = {24'h0, vb1_ff};
      baddr(IDX_B2_VOUT): rdata = {24'h0, vb2_ff};
      baddr(IDX_B3_VOUT): rdata = {24'h0, vb3_ff};
      baddr(IDX_STATUS): rdata = {18'h0, armed_ff, b3_slp_ff, short_ff, pfm_ff,
                                  bypass_ff, st_ff};
      default: mapped = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      if (psel && !penable && !pwrite) begin
        prdata <= rdata;
      end
    end
  end

  // ==========================================================
  // Delay counter, restarts on every state change
  assign done = (st_ff == S_DECIDE) ? cnt_ff >= 32'(DECIDE_CYC - 1)
                                    : cnt_ff >= 32'(STEP_CYC - 1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= 32'h0;
    end else if (srst || nxt_st != st_ff) begin
      cnt_ff <= 32'h0;
    end else if (!done) begin
      cnt_ff <= cnt_ff + 32'h1;
    end
  end

  // Sleep pin is only honoured once the power-up hold-off expires
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      arm_cnt_ff <= 32'h0;
      armed_ff <= 1'b0;
    end else if (srst) begin
      arm_cnt_ff <= 32'h0;
      armed_ff <= 1'b0;
    end else if (!armed_ff) begin
      arm_cnt_ff <= arm_cnt_ff + 32'h1;
      armed_ff <= arm_cnt_ff >= 32'(ARM_CYC - 2);
    end
  end

  // ==========================================================
  // Main sequencer
  logic slp, en_b1, en_b2;
  assign slp = sleep_request && armed_ff;
  assign en_b1 = ctrl_ff[CTRL_B1EN_BIT];
  assign en_b2 = ctrl_ff[CTRL_B2EN_BIT];

  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      S_OFF: nxt_st = S_DECIDE;
      S_DECIDE: if (done) nxt_st = S_LDO;
      S_LDO: if (done) nxt_st = S_B1;
      S_B1: if (done) nxt_st = S_B2;
      S_B2: if (done) nxt_st = S_RUN;
      S_RUN: begin
        if (|(out_of_reg & buck_en)) begin
          nxt_st = S_FAULT;
        end else if (slp) begin
          nxt_st = (en_b1 || en_b2) ? S_SLP_B3 : S_SLEEP;
        end
      end
      // A step always runs its full delay before reversing
      S_SLP_B3: if (done) nxt_st = slp ? S_SLP_B2 : S_WAKE;
      S_SLP_B2: if (done) nxt_st = slp ? S_SLEEP : S_WAKE;
      S_SLEEP: if (!slp) nxt_st = S_WAKE;
      S_WAKE: if (done) nxt_st = slp ? S_SLP_B3 : S_RUN;
      S_FAULT: if (!(|out_of_reg)) nxt_st = S_LDO;
      default: nxt_st = S_OFF;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= S_OFF;
    end else if (srst) begin
      st_ff <= S_OFF;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Sleep bookkeeping: buck three level and whether buck two went down
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      b3_slp_ff <= 1'b0;
      b2_down_ff <= 1'b0;
    end else if (srst || nxt_st == S_RUN || nxt_st == S_FAULT) begin
      b3_slp_ff <= 1'b0;
      b2_down_ff <= 1'b0;
    end else begin
      if (st_ff == S_RUN && nxt_st == S_SLP_B3) begin
        b3_slp_ff <= 1'b1;
      end
      if (nxt_st == S_SLP_B2 && st_ff != S_SLP_B2) begin
        b2_down_ff <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Buck enables and outputs
  logic [2:0] nxt_en;
  always_comb begin
    nxt_en = 3'h0;
    case (st_ff)
      S_B1: nxt_en = {2'b00, en_b1};
      S_B2: nxt_en = {1'b0, en_b2, en_b1};
      S_RUN, S_SLP_B3: nxt_en = {1'b1, en_b2, en_b1};
      S_SLP_B2: nxt_en = {1'b1, 1'b0, en_b1};
      S_SLEEP: nxt_en = 3'b100;
      S_WAKE: nxt_en = {1'b1, en_b2 && !b2_down_ff, en_b1};
      default: nxt_en = 3'h0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ldo_en <= 1'b0;
      buck_en <= 3'h0;
      discharge_on <= 2'b11;
      b1_vout <= VOUT_B1_3V0;
      b2_vout <= VOUT_B2_3V0;
      b3_vout <= VOUT_B3_1V2;
    end else begin
      ldo_en <= st_ff != S_OFF && st_ff != S_DECIDE;
      buck_en <= nxt_en;
      discharge_on <= ~nxt_en[1:0];
      b1_vout <= vb1_ff;
      b2_vout <= vb2_ff;
      b3_vout <= b3_slp_ff ? sleep_lvl_ff : vb3_ff;
    end
  end

  // ==========================================================
  // Bypass decision: taken at start-up, only ever released later
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bypass_ff <= 2'b00;
    end else if (srst) begin
      bypass_ff <= 2'b00;
    end else if (st_ff == S_DECIDE && done) begin
      bypass_ff <= {2{vin_below_3v6}};
    end else begin
      if (buck_en[0] && vin_above_3v5) bypass_ff[0] <= 1'b0;
      if (buck_en[1] && vin_above_2v6) bypass_ff[1] <= 1'b0;
    end
  end

  // ==========================================================
  // Per-buck switch control
  logic [2:0] fff;
  assign fff = ctrl_ff[CTRL_FFF_LSB +: 3];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pfm_ff <= 3'h0;
      short_ff <= 3'h0;
      hs_on <= 3'h0;
      ls_on <= 3'h0;
      bypass_fet_on <= 1'b0;
      pfm_mode <= 3'h0;
      for (int i = 0; i < 3; i++) begin
        ph_ff[i] <= PH_IDLE;
      end
    end else begin
      bypass_fet_on <= buck_en[0] && bypass_ff[0];
      pfm_mode <= pfm_ff;
      for (int i = 0; i < 3; i++) begin
        if (!buck_en[i]) begin
          pfm_ff[i] <= 1'b0;
          short_ff[i] <= 1'b0;
          ph_ff[i] <= PH_IDLE;
          hs_on[i] <= 1'b0;
          ls_on[i] <= 1'b0;
        end else if (i < 2 && bypass_ff[i]) begin
          hs_on[i] <= 1'b1;
          ls_on[i] <= 1'b0;
        end else if (short_ff[i] || short_det[i]) begin
          // Low side held until current decays, stopping runaway
          hs_on[i] <= 1'b0;
          ls_on[i] <= !il_below_low[i];
          short_ff[i] <= !il_below_low[i];
          ph_ff[i] <= PH_IDLE;
        end else if (dropout_req[i]) begin
          hs_on[i] <= 1'b1;
          ls_on[i] <= 1'b0;
        end else if (pfm_ff[i]) begin
          if (fb_below_lo2[i] || fff[i]) begin
            pfm_ff[i] <= 1'b0;
          end
          case (ph_ff[i])
            PH_IDLE: if (fb_below_lo[i]) ph_ff[i] <= PH_HS;
            PH_HS: if (fb_above_hi[i]) ph_ff[i] <= PH_LS;
            PH_LS: if (il_zero[i]) ph_ff[i] <= fb_above_hi[i] ? PH_IDLE : PH_HS;
            default: ph_ff[i] <= PH_IDLE;
          endcase
          hs_on[i] <= ph_ff[i] == PH_HS;
          ls_on[i] <= ph_ff[i] == PH_LS;
        end else begin
          if (light_load[i] && !fff[i]) begin
            pfm_ff[i] <= 1'b1;
          end
          // Entering light load below the upper threshold starts on the high side
          ph_ff[i] <= fb_above_hi[i] ? PH_IDLE : PH_HS;
          hs_on[i] <= pwm_on_req[i];
          ls_on[i] <= !pwm_on_req[i];
        end
      end
    end
  end

  // ==========================================================
  // Soft start: current limit climbs one step per interval
  logic [31:0] ss_cnt_ff [3];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ilim_step <= '0;
      for (int i = 0; i < 3; i++) begin
        ss_cnt_ff[i] <= 32'h0;
      end
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (!buck_en[i]) begin
          ilim_step[i*ILIM_W +: ILIM_W] <= '0;
          ss_cnt_ff[i] <= 32'h0;
        end else if (ilim_step[i*ILIM_W +: ILIM_W] != {ILIM_W{1'b1}}) begin
          if (ss_cnt_ff[i] >= 32'(SS_CYC - 1)) begin
            ss_cnt_ff[i] <= 32'h0;
            ilim_step[i*ILIM_W +: ILIM_W] <=
              ilim_step[i*ILIM_W +: ILIM_W] + ILIM_W'(1);
          end else begin
            ss_cnt_ff[i] <= ss_cnt_ff[i] + 32'h1;
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

// >>> tb/pps_sequencer_chk.sv
`timescale 1ns/100ps
`default_nettype none
module pps_sequencer_chk (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Supply, host pin and comparator inputs
  input wire logic vin_above_uvlo,
  input wire logic reset_pin_n,
  input wire logic sleep_request,
  input wire logic [2:0] short_det,
  input wire logic [2:0] dropout_req,
  input wire logic [2:0] out_of_reg,
  // Power stage controls
  input wire logic ldo_en,
  input wire logic [2:0] buck_en,
  input wire logic [2:0] hs_on,
  input wire logic [2:0] ls_on,
  input wire logic bypass_fet_on,
  input wire logic [1:0] discharge_on
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================================
  // Switch stage
  no_shoot_a: assert property ((hs_on & ls_on) == 3'h0)
    else $error("both switches of a buck on");
  bypass_fet_a: assert property (bypass_fet_on |-> hs_on[0])
    else $error("bypass switch without high side");
  dropout_hs_a: assert property (
    (buck_en[2] && dropout_req[2] && !short_det[2]) [*2] |=>
      !buck_en[2] || (hs_on[2] && !ls_on[2]))
    else $error("dropout without full high side");
  disch_map_a: assert property (discharge_on == ~buck_en[1:0])
    else $error("discharge does not follow disable");
  // ==========================================================
  // Sequencing; a soft reset takes one cycle to reach the state, one more the outputs
  ldo_hold_a: assert property (
    ldo_en && vin_above_uvlo && reset_pin_n && $past(vin_above_uvlo) && $past(reset_pin_n)
      |=> ldo_en)
    else $error("linear regulator dropped");
  ldo_first_a: assert property (buck_en != 3'h0 |-> ldo_en)
    else $error("buck on before linear regulator");
  uvlo_off_a: assert property (!vin_above_uvlo |-> ##2 (!ldo_en && buck_en == 3'h0))
    else $error("lockout left outputs on");
  pin_rst_a: assert property (!reset_pin_n |-> ##2 (!ldo_en && buck_en == 3'h0))
    else $error("reset pin left outputs on");
  fault_off_a: assert property (buck_en == 3'h7 && out_of_reg[0] |-> ##[1:3] buck_en == 3'h0)
    else $error("out of regulation not shut down");
  sleep_cv: cover property ($rose(sleep_request));
  fault_cv: cover property (buck_en == 3'h7 && out_of_reg != 3'h0);
  dropout_cv: cover property (buck_en[2] && dropout_req[2] && hs_on[2]);
endmodule
bind pps_sequencer pps_sequencer_chk pps_sequencer_chk_inst (
  .pclk, .presetn, .vin_above_uvlo, .reset_pin_n, .sleep_request, .short_det, .dropout_req,
  .out_of_reg, .ldo_en, .buck_en, .hs_on, .ls_on, .bypass_fet_on, .discharge_on
);
`default_nettype wire

// >>> tb/pps_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module pps_host_model (
  // Clock
  input wire logic pclk,
  // Host pins
  output logic sleep_request,
  output logic reset_pin_n
);
  // Pins rest at their pull levels
  initial begin
    sleep_request = 1'b0;
    reset_pin_n = 1'b1;
  end
  task automatic set_sleep(input logic lvl);
    @(posedge pclk);
    sleep_request <= lvl;
  endtask
  task automatic pulse_reset(input int n);
    @(posedge pclk);
    reset_pin_n <= 1'b0;
    repeat (n) @(posedge pclk);
    reset_pin_n <= 1'b1;
  endtask
endmodule
`default_nettype wire

// >>> tb/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
  import pps_pkg::*;
  localparam int DEC = 20;
  localparam int STP = 10;
  localparam int ARM = 200;
  localparam logic [11:0] A_B1 = {2'b00, IDX_B1_VOUT, 2'b00};
  localparam logic [11:0] A_SLP = {2'b00, IDX_SLEEP_LVL, 2'b00};
  localparam logic [11:0] A_CTL = {2'b00, IDX_BUCK_CTRL, 2'b00};
  localparam logic [11:0] A_ST = {2'b00, IDX_STATUS, 2'b00};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, er;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic vin = 1'b1, v36 = 1'b1, v35 = 1'b0, v26 = 1'b0, sel2 = 1'b0, sel3 = 1'b0;
  logic [2:0] hi = 3'h0, lo = 3'h0, lo2 = 3'h0, iz = 3'h0, ilb = 3'h0, ll = 3'h0;
  logic [2:0] pwm = 3'h0, sh = 3'h0, dr = 3'h0, oor = 3'h0, buck_en, hs_on, ls_on, pfm_mode;
  logic ldo_en, bypass_fet_on, sleep_request, reset_pin_n;
  logic [1:0] discharge_on;
  logic [8:0] ilim_step;
  logic [7:0] b1_vout, b2_vout, b3_vout;
  logic [2:0] il0;
  logic [5:0] mon;
  int fail_count = 0, n_tests = 0, cyc = 0, t0 = 0, c;
  assign mon = {pfm_mode[2], b3_vout == 8'h0c, ldo_en, buck_en};
  pps_sequencer #(.DECIDE_CYC(DEC), .STEP_CYC(STP), .ARM_CYC(ARM), .SS_CYC(4), .ILIM_W(3))
    pps_sequencer_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .vin_above_uvlo(vin), .reset_pin_n(reset_pin_n), .sleep_request(sleep_request),
    .buck2_voltage_select(sel2), .buck3_voltage_select(sel3), .vin_below_3v6(v36),
    .vin_above_3v5(v35), .vin_above_2v6(v26), .fb_above_hi(hi), .fb_below_lo(lo),
    .fb_below_lo2(lo2), .il_zero(iz), .il_below_low(ilb), .light_load(ll), .pwm_on_req(pwm),
    .short_det(sh), .dropout_req(dr), .out_of_reg(oor), .ldo_en(ldo_en), .buck_en(buck_en),
    .hs_on(hs_on), .ls_on(ls_on), .bypass_fet_on(bypass_fet_on), .discharge_on(discharge_on),
    .pfm_mode(pfm_mode), .ilim_step(ilim_step), .b1_vout(b1_vout), .b2_vout(b2_vout),
    .b3_vout(b3_vout));
  pps_host_model pps_host_model_inst (
    .pclk(pclk), .sleep_request(sleep_request), .reset_pin_n(reset_pin_n));
  always #10 pclk = ~pclk;
  // ==========================================================
  // Helpers
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // The ceiling is about twenty times the expected run of about 400 cycles
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      fail_count++;
      wrap_up();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the bench timeout ends a wait for the slave
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input string m);
    apb(1'b0, a, 32'h0);
    chk(rd, exp, m);
  endtask
  // Cycles until monitored bit i shows v, capped
  task automatic gap(input int i, input logic v, output int n);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (mon[i] !== v && n < 1000);
  endtask
  // Buck three comparators: hi, zero current, lo, lo2, dropout, short
  task automatic sw(input logic [5:0] v, input logic [1:0] e, input string m);
    hi <= {v[5], 2'b00};
    iz <= {v[4], 2'b00};
    lo <= {v[3], 2'b00};
    lo2 <= {v[2], 2'b00};
    dr <= {v[1], 2'b00};
    sh <= {v[0], 2'b00};
    repeat (4) @(posedge pclk);
    chk({30'h0, hs_on[2], ls_on[2]}, {30'h0, e}, m);
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    repeat (10) @(posedge pclk);
    chk({ldo_en, buck_en, discharge_on}, 32'h3, "reset outputs");
    chk({b1_vout, b2_vout, b3_vout}, 32'h3c3c18, "reset levels");
    presetn <= 1'b1;
    t0 = cyc;
    gap(3, 1'b1, c);
    chk(32'(c >= DEC && c <= 26), 32'h1, "decide wait");
    gap(0, 1'b1, c);
    chk(c, STP, "buck1 gap");
    gap(1, 1'b1, c);
    chk(c, STP, "buck2 gap");
    gap(2, 1'b1, c);
    chk(c, STP, "buck3 gap");
    il0 = ilim_step[8:6];
    chk({b2_vout, b3_vout}, 32'h2414, "select low levels");
    chk({bypass_fet_on, hs_on[1:0]}, 32'h7, "bypass start");
    apb(1'b0, A_ST, 32'h0);
    chk({30'h0, rd[5:4]}, 32'h3, "bypass status");
    rdc(A_SLP, 32'h10, "sleep level default");
    rdc(A_CTL, 32'h3, "ctrl default");
    apb(1'b0, 12'h03c, 32'h0);
    chk({er, rd[30:0]}, 32'h80000000, "unmapped");
    chk(32'(ilim_step[8:6] > il0), 32'h1, "limit steps up");
    sel2 <= 1'b1;
    sel3 <= 1'b1;
    repeat (5) @(posedge pclk);
    chk({b2_vout, b3_vout}, 32'h2414, "select ignored");
    v35 <= 1'b1;
    v26 <= 1'b1;
    repeat (4) @(posedge pclk);
    chk(bypass_fet_on, 32'h0, "bypass dropped");
    apb(1'b0, A_ST, 32'h0);
    chk({30'h0, rd[5:4]}, 32'h0, "bypass status off");
    $display("test startup done");
    ll <= 3'b100;
    gap(5, 1'b1, c);
    chk(32'(c < 1000), 32'h1, "enter light load");
    sw(6'b000000, 2'b10, "pulse high side");
    sw(6'b100000, 2'b01, "pulse low side");
    sw(6'b110000, 2'b00, "pulse idle");
    sw(6'b010000, 2'b00, "idle above lo");
    sw(6'b011000, 2'b10, "restart below lo");
    // Load steps up: the light-load request drops as the output sags past lo2
    ll <= 3'b000;
    lo2 <= 3'b100;
    repeat (4) @(posedge pclk);
    chk(pfm_mode[2], 32'h0, "forced fixed frequency");
    sw(6'b000010, 2'b10, "dropout");
    sw(6'b000011, 2'b01, "short holds low side");
    ilb <= 3'b100;
    repeat (4) @(posedge pclk);
    chk(ls_on[2], 32'h0, "short low side released");
    pwm <= 3'b100;
    sw(6'b000000, 2'b10, "fixed frequency on phase");
    pwm <= 3'b000;
    sw(6'b000000, 2'b01, "fixed frequency off phase");
    $display("test switching done");
    apb(1'b1, A_SLP, 32'h0c);
    pps_host_model_inst.set_sleep(1'b1);
    gap(4, 1'b1, c);
    chk(32'(cyc - t0 >= ARM), 32'h1, "sleep hold-off");
    gap(1, 1'b0, c);
    chk(c, STP, "buck2 off gap");
    chk(discharge_on, 32'h2, "buck2 discharge");
    gap(0, 1'b0, c);
    chk(c, STP, "buck1 off gap");
    pps_host_model_inst.set_sleep(1'b0);
    gap(0, 1'b1, c);
    chk(b3_vout, 32'h0c, "b3 waits");
    gap(1, 1'b1, c);
    chk(c, STP, "wake gap");
    chk(b3_vout, 32'h14, "b3 restored");
    $display("test sleep done");
    apb(1'b1, A_CTL, 32'h2);
    repeat (4) @(posedge pclk);
    chk({buck_en, discharge_on}, 32'h19, "buck1 host off");
    apb(1'b1, A_CTL, 32'h0);
    pps_host_model_inst.set_sleep(1'b1);
    repeat (3 * STP) @(posedge pclk);
    chk(b3_vout, 32'h14, "b3 keeps level");
    pps_host_model_inst.set_sleep(1'b0);
    repeat (3 * STP) @(posedge pclk);
    apb(1'b1, A_CTL, 32'h3);
    repeat (4) @(posedge pclk);
    chk(buck_en, 32'h7, "bucks back");
    apb(1'b1, A_CTL, 32'h13);
    ll <= 3'b100;
    repeat (6) @(posedge pclk);
    chk(pfm_mode[2], 32'h0, "forced fixed frequency bit");
    ll <= 3'b000;
    oor <= 3'b001;
    repeat (4) @(posedge pclk);
    chk({ldo_en, buck_en}, 32'h8, "fault shutdown");
    oor <= 3'b000;
    gap(0, 1'b1, c);
    chk(32'(c <= 2 * STP + 4), 32'h1, "fault restart");
    $display("test host and fault done");
    apb(1'b1, A_B1, 32'h20);
    rdc(A_B1, 32'h20, "b1 write");
    pps_host_model_inst.pulse_reset(3);
    rdc(A_B1, 32'h3c, "b1 after reset pin");
    rdc(A_CTL, 32'h3, "ctrl after reset pin");
    vin <= 1'b0;
    repeat (3) @(posedge pclk);
    chk(ldo_en, 32'h0, "lockout off");
    vin <= 1'b1;
    v36 <= 1'b0;
    gap(3, 1'b1, c);
    chk(32'(c >= DEC && c <= 26), 32'h1, "new power-up");
    apb(1'b0, A_ST, 32'h0);
    chk({30'h0, rd[5:4]}, 32'h0, "regulated start");
    $display("test reset done");
    wrap_up();
  end
endmodule
`default_nettype wire
